// file: hw/mcf_map.svh
// register-free constant map for the function 0x46 configuration handler
`ifndef MCF_MAP_SVH
`define MCF_MAP_SVH
`define MCF_FUNC_CODE        8'h46
`define MCF_FUNC_ERR         8'hC6
`define MCF_SUB_SET_POL      8'h29
`define MCF_SUB_GET_POL      8'h2A
`define MCF_SUB_GET_DLY      8'h35
`define MCF_SUB_SET_DLY      8'h36
`define MCF_EXC_ILL_FUNC     8'h01
`define MCF_EXC_ILL_VALUE    8'h03
`define MCF_ADDR_MIN         8'h01
`define MCF_ADDR_MAX         8'hF7
`define MCF_POL_IN_BIT       0
`define MCF_POL_OUT_BIT      1
`define MCF_POL_RESET        2'h0
`define MCF_DLY_RESET        8'h00
`define MCF_SAFE_OUT         8'h00
`define MCF_CLK_HZ           25000000
`define MCF_MS_NS            1000000
`define MCF_CLK_NS           40
`define MCF_CYC_PER_MS       (`MCF_MS_NS / `MCF_CLK_NS)
`define MCF_HOST_WD_MS       1000
`define MCF_MOD_WD_MS        100
`endif

// file: hw/mcf_pkg.sv
// types shared by the configuration handler
package mcf_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} mcf_byte_type;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_RECV  = 5'b00010,
		ST_EXEC  = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_SEND  = 5'b10000
	} mcf_state_type;
endpackage

// file: hw/mcf_handler.sv
// function 0x46 configuration sub-function handler with dual watchdog
//
// Overview of operation
// (RULE_01) sub-function 0x2A reply echoes address, function, sub-function plus polarity byte 0..3
// (RULE_02) bit 0 set inverts digital input reading; clear means high voltage reads 0
// (RULE_03) bit 1 set inverts relay drive; clear means output 1 activates relay
// (RULE_04) failed request answers address, 0xC6 and one standard exception code
// (RULE_05) sub-function 0x35 reply echoes header plus stored response delay byte
// (RULE_06) sub-function 0x36 stores delay byte and echoes header plus accepted byte
// (RULE_07) response delay byte counts milliseconds, 0x1E gives 30 ms
// (RULE_08) host watchdog timeout drives all outputs to safe state
// (RULE_09) module watchdog resets the module when operation stalls
// (RULE_10) sub-function 0x29 writes polarity, reply result byte zero on success
// (RULE_11) reply starts only after configured delay past end of request frame
// (RULE_12) polarity bits 7..2 read as zero and are ignored on write
`timescale 1ns/1ns
`include "mcf_map.svh"

module mcf_handler
	import mcf_pkg::*;
#(
	parameter int unsigned CYC_PER_MS  = `MCF_CYC_PER_MS,
	parameter int unsigned HOST_WD_MS  = `MCF_HOST_WD_MS,
	parameter int unsigned MOD_WD_CYC  = `MCF_MOD_WD_MS * `MCF_CYC_PER_MS
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         clk_en,
	input  wire logic [7:0]   slave_addr,
	input  wire mcf_byte_type rx_byte,
	input  wire logic         rx_valid,
	input  wire logic         tx_ready,
	input  wire logic         alive_kick,
	input  wire logic [7:0]   din_pins,
	input  wire logic [7:0]   dout_value,
	output logic              rx_ready,
	output mcf_byte_type      tx_byte,
	output logic              tx_valid,
	output logic [7:0]        din_value,
	output logic [7:0]        relay_drive,
	output logic              host_wd_expired,
	output logic              module_reset_req,
	output logic [7:0]        polarity_status,
	output logic [7:0]        delay_ms
);

	// ****************************************
	// state
	// ****************************************
	mcf_state_type state_q;
	logic [7:0]    rbuf_q [0:4];
	logic [2:0]    rcnt_q;
	logic [7:0]    tbuf_q [0:3];
	logic [2:0]    tlen_q;
	logic [2:0]    tidx_q;
	logic [1:0]    pol_q;
	logic [7:0]    dly_q;
	logic [7:0]    ms_left_q;
	logic [31:0]   cyc_q;
	logic [31:0]   host_ms_q;
	logic [31:0]   host_cyc_q;
	logic [31:0]   mod_cnt_q;
	logic          wd_expired_q;
	logic          for_me;
	logic [2:0]    out_idx;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a >= `MCF_ADDR_MIN) && (a <= `MCF_ADDR_MAX);
	endfunction

	assign for_me = (rbuf_q[0] == slave_addr) && addr_ok(rbuf_q[0]);

	// index of the reply byte that stands after this edge; only two bits address the buffer
	assign out_idx = (tx_ready && tx_valid) ? tidx_q + 3'h1 : tidx_q;

	// ****************************************
	// frame sequencer
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q   <= ST_IDLE;
			rcnt_q    <= 3'h0;
			tlen_q    <= 3'h0;
			tidx_q    <= 3'h0;
			ms_left_q <= 8'h00;
			cyc_q     <= 32'h0;
			pol_q     <= `MCF_POL_RESET;
			dly_q     <= `MCF_DLY_RESET;
			for (int i = 0; i < 5; i++) rbuf_q[i] <= 8'h00;
			for (int i = 0; i < 4; i++) tbuf_q[i] <= 8'h00;
		end else if (clk_en) begin
			unique case (state_q)
				ST_IDLE, ST_RECV: begin
					// bytes count only when ready was shown, so host and handler agree on every hand-off made while clk_en is high
					if (rx_valid && rx_ready) begin
						// overlong frames keep only the first five bytes
						if (rcnt_q < 3'h5) begin
							rbuf_q[rcnt_q] <= rx_byte.data;
							rcnt_q         <= rcnt_q + 3'h1;
						end
						state_q <= rx_byte.last ? ST_EXEC : ST_RECV;
					end
				end
				ST_EXEC: begin
					rcnt_q    <= 3'h0;
					tidx_q    <= 3'h0;
					cyc_q     <= 32'h0;
					ms_left_q <= dly_q;
					tbuf_q[0] <= rbuf_q[0];
					tbuf_q[1] <= rbuf_q[1];
					tbuf_q[2] <= rbuf_q[2];
					tlen_q    <= 3'h4;
					state_q   <= ST_WAIT;
					if (!for_me || rbuf_q[1] != `MCF_FUNC_CODE) begin
						// not ours: stay silent
						state_q <= ST_IDLE;
					end else if (rbuf_q[2] == `MCF_SUB_GET_POL && rcnt_q == 3'h3) begin
						// (RULE_01) polarity read reply
						// (RULE_12) reserved bits zero
						tbuf_q[3] <= {6'h00, pol_q};
					end else if (rbuf_q[2] == `MCF_SUB_SET_POL && rcnt_q == 3'h4) begin
						// (RULE_10) polarity write, result byte
						// (RULE_12) upper bits ignored
						pol_q     <= rbuf_q[3][1:0];
						tbuf_q[3] <= 8'h00;
					end else if (rbuf_q[2] == `MCF_SUB_GET_DLY && rcnt_q == 3'h3) begin
						// (RULE_05) delay read reply
						tbuf_q[3] <= dly_q;
					end else if (rbuf_q[2] == `MCF_SUB_SET_DLY && rcnt_q == 3'h4) begin
						// (RULE_06) store and echo delay
						dly_q     <= rbuf_q[3];
						tbuf_q[3] <= rbuf_q[3];
						ms_left_q <= rbuf_q[3];
					end else begin
						// (RULE_04) exception reply
						tbuf_q[1] <= `MCF_FUNC_ERR;
						tbuf_q[2] <= (rbuf_q[2] == `MCF_SUB_GET_POL || rbuf_q[2] == `MCF_SUB_SET_POL ||
							rbuf_q[2] == `MCF_SUB_GET_DLY || rbuf_q[2] == `MCF_SUB_SET_DLY) ?
							`MCF_EXC_ILL_VALUE : `MCF_EXC_ILL_FUNC;
						tlen_q    <= 3'h3;
					end
				end
				ST_WAIT: begin
					// (RULE_11) hold reply for delay
					// (RULE_07) one count per millisecond
					if (ms_left_q == 8'h00) begin
						state_q <= ST_SEND;
					end else if (cyc_q == CYC_PER_MS - 1) begin
						cyc_q     <= 32'h0;
						ms_left_q <= ms_left_q - 8'h01;
					end else begin
						cyc_q <= cyc_q + 32'h1;
					end
				end
				ST_SEND: begin
					if (tx_ready && tx_valid) begin
						tidx_q <= tidx_q + 3'h1;
						if (tidx_q == tlen_q - 3'h1) state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// host and module watchdogs
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_cyc_q   <= 32'h0;
			host_ms_q    <= 32'h0;
			wd_expired_q <= 1'b0;
		end else if (clk_en) begin
			// (RULE_08) any received byte feeds host watchdog
			if (rx_valid) begin
				host_cyc_q   <= 32'h0;
				host_ms_q    <= 32'h0;
				wd_expired_q <= 1'b0;
			end else if (host_ms_q >= HOST_WD_MS) begin
				wd_expired_q <= 1'b1;
			end else if (host_cyc_q == CYC_PER_MS - 1) begin
				host_cyc_q <= 32'h0;
				host_ms_q  <= host_ms_q + 32'h1;
			end else begin
				host_cyc_q <= host_cyc_q + 32'h1;
			end
		end
	end

	// counts even when clk_en is low: a frozen module is exactly what it watches
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mod_cnt_q        <= 32'h0;
			module_reset_req <= 1'b0;
		end else begin
			// (RULE_09) stalled module forces reset
			if (alive_kick && clk_en) begin
				mod_cnt_q        <= 32'h0;
				module_reset_req <= 1'b0;
			end else if (mod_cnt_q >= MOD_WD_CYC - 1) begin
				module_reset_req <= 1'b1;
			end else begin
				mod_cnt_q <= mod_cnt_q + 32'h1;
			end
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_ready        <= 1'b0;
			tx_valid        <= 1'b0;
			tx_byte         <= '0;
			din_value       <= 8'h00;
			relay_drive     <= `MCF_SAFE_OUT;
			host_wd_expired <= 1'b0;
			polarity_status <= 8'h00;
			delay_ms        <= 8'h00;
		end else if (clk_en) begin
			// ready follows the next state, so it falls once the last request byte is taken; bytes past the fifth are still shown ready and then dropped
			rx_ready        <= ((state_q == ST_IDLE || state_q == ST_RECV) &&
				!(rx_valid && rx_ready && rx_byte.last)) ||
				((state_q == ST_SEND) && tx_ready && tx_valid && tidx_q == tlen_q - 3'h1);
			tx_valid        <= (state_q == ST_SEND) && !(tx_ready && tx_valid && tidx_q == tlen_q - 3'h1);
			tx_byte.data    <= tbuf_q[out_idx[1:0]];
			tx_byte.last    <= (out_idx == tlen_q - 3'h1);
			// (RULE_02) input polarity mapping
			din_value       <= pol_q[`MCF_POL_IN_BIT] ? din_pins : ~din_pins;
			// (RULE_08) safe state on timeout
			// (RULE_03) output polarity mapping
			relay_drive     <= wd_expired_q ? `MCF_SAFE_OUT :
				(pol_q[`MCF_POL_OUT_BIT] ? ~dout_value : dout_value);
			host_wd_expired <= wd_expired_q;
			polarity_status <= {6'h00, pol_q};
			delay_ms        <= dly_q;
		end
	end

endmodule

// file: verification/mcf_handler_asserts.sv
// port-level assertions for the configuration handler
`timescale 1ns/1ns
module mcf_handler_asserts #(
	parameter int unsigned MOD_WD_CYC = 50
) (
	input wire logic                  clk,
	input wire logic                  rstn,
	input wire logic                  clk_en,
	input wire logic                  alive_kick,
	input wire logic [7:0]            din_pins,
	input wire logic [7:0]            dout_value,
	input wire logic                  rx_valid,
	input wire logic                  rx_ready,
	input wire logic                  tx_ready,
	input wire mcf_pkg::mcf_byte_type tx_byte,
	input wire logic                  tx_valid,
	input wire logic [7:0]            din_value,
	input wire logic [7:0]            relay_drive,
	input wire logic                  host_wd_expired,
	input wire logic                  module_reset_req,
	input wire logic [7:0]            polarity_status
);
	logic [7:0] idle_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// saturating, so a long stall never wraps back to zero
	always_ff @(posedge clk or negedge rstn)
		if (!rstn) idle_q <= 8'h00;
		else idle_q <= alive_kick ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
	pol_reserved_a: assert property (polarity_status[7:2] == 6'h00)
		else $error("reserved polarity bits set");
	din_map_a: assert property ($past(rstn) && $past(clk_en) && $stable(din_pins)
		&& $stable(polarity_status) |-> din_value == (polarity_status[0] ? din_pins : ~din_pins))
		else $error("input map wrong");
	relay_map_a: assert property ($past(rstn) && $past(clk_en) && $stable(dout_value)
		&& $stable(polarity_status) && $stable(host_wd_expired) |-> relay_drive == (host_wd_expired ? 8'h00
		: (polarity_status[1] ? ~dout_value : dout_value))) else $error("relay map wrong");
	frozen_out_a: assert property (!clk_en |=> $stable(din_value) && $stable(relay_drive)
		&& $stable(tx_valid) && $stable(polarity_status)) else $error("outputs moved while frozen");
	host_kick_a: assert property (clk_en && rx_valid && rx_ready |-> ##[1:3] !host_wd_expired)
		else $error("host watchdog not cleared");
	mod_wd_a: assert property (idle_q > MOD_WD_CYC + 2 |-> module_reset_req)
		else $error("module watchdog silent");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("reply byte not held");
	tx_last_a: assert property (clk_en && tx_valid && tx_ready && tx_byte.last |=> !tx_valid)
		else $error("reply runs past last");
	rx_busy_a: assert property (tx_valid |-> !rx_ready)
		else $error("request taken while replying");
endmodule

// file: verification/mcf_host_model.sv
// host stand-in: feeds request bytes and takes reply bytes
`timescale 1ns/1ns
module mcf_host_model (
	input  wire logic                  clk,
	input  wire logic                  slow,
	input  wire logic                  rx_ready,
	input  wire mcf_pkg::mcf_byte_type tx_byte,
	input  wire logic                  tx_valid,
	output mcf_pkg::mcf_byte_type      rx_byte,
	output logic                       rx_valid,
	output logic                       tx_ready
);
	mcf_pkg::mcf_byte_type rsp[$];
	initial begin
		rx_byte = '0;
		rx_valid = 1'b0;
		tx_ready = 1'b1;
	end
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			rx_byte <= {b[i], i == b.size() - 1};
			rx_valid <= 1'b1;
			do @(posedge clk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		// released line flips so a stale byte cannot pass as fresh
		rx_byte <= ~rx_byte;
	endtask
	// slow mode drops ready on every other clock cycle
	always @(posedge clk) begin
		if (tx_valid && tx_ready) rsp.push_back(tx_byte);
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end
endmodule

// file: verification/mcf_handler_tb.sv
// self-checking bench for the configuration handler
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("Error %0t: got %h want %h", $time, a, b); end end
module mcf_handler_tb;
	typedef struct {int n; logic [31:0] q; int m; logic [31:0] r;} mcf_row_type;
	localparam int unsigned CPM = 4;
	localparam int unsigned MWD = 50;
	logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, kick_on = 1'b1, slow = 1'b0, alive_kick = 1'b0;
	logic [7:0] din_pins = 8'h5A, dout_value = 8'h3C, own_addr = 8'h11;
	logic rx_valid, tx_ready, rx_ready, tx_valid, host_wd_expired, module_reset_req;
	mcf_pkg::mcf_byte_type rx_byte, tx_byte;
	logic [7:0] din_value, relay_drive, polarity_status, delay_ms;
	int checks = 0, err_total = 0, cyc = 0, w, ts;
	mcf_row_type rows[9] = '{'{3, 32'h11462A, 4, 32'h11462A00}, '{4, 32'h11462902, 4, 32'h11462900},
		'{3, 32'h11462A, 4, 32'h11462A02}, '{4, 32'h114629FD, 4, 32'h11462900},
		'{3, 32'h11462A, 4, 32'h11462A01}, '{4, 32'h1146361E, 4, 32'h1146361E},
		'{3, 32'h114620, 3, 32'h11C601}, '{4, 32'h11462A00, 3, 32'h11C603}, '{3, 32'h12462A, 0, 0}};
	mcf_handler #(.CYC_PER_MS(CPM), .HOST_WD_MS(60), .MOD_WD_CYC(MWD)) i_dut (.clk, .rstn, .clk_en,
		.slave_addr(own_addr), .rx_byte, .rx_valid, .tx_ready, .alive_kick, .din_pins, .dout_value, .rx_ready,
		.tx_byte, .tx_valid, .din_value, .relay_drive, .host_wd_expired, .module_reset_req, .polarity_status,
		.delay_ms);
	mcf_host_model i_host (.clk, .slow, .rx_ready, .tx_byte, .tx_valid, .rx_byte, .rx_valid, .tx_ready);
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		alive_kick <= kick_on && cyc % 10 == 0;
		if (cyc == 8000) begin
			$display("Error %0t: timeout", $time);
			err_total++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic run(input mcf_row_type r);
		logic [7:0] b[$];
		for (int i = r.n - 1; i >= 0; i--) b.push_back(r.q[8*i+:8]);
		repeat (2) @(posedge clk);
		i_host.rsp.delete();
		i_host.send(b);
		w = 0;
		ts = -1;
		while ((r.m == 0 || i_host.rsp.size() < r.m) && w < (r.m ? 400 : 320)) begin
			@(posedge clk);
			w++;
			if (ts < 0 && tx_valid === 1'b1) ts = w;
		end
		`CHK(i_host.rsp.size(), r.m)
		foreach (i_host.rsp[k]) `CHK(i_host.rsp[k], {r.r[8*(r.m-1-k)+:8], k == r.m - 1})
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(polarity_status, 8'h00)
		`CHK(delay_ms, 8'h00)
		`CHK(din_value, 8'hA5)
		`CHK(relay_drive, 8'h3C)
		foreach (rows[i]) begin
			slow <= i[0];
			din_pins <= din_pins + 8'h11;
			run(rows[i]);
		end
		`CHK(host_wd_expired, 1'b1)
		`CHK(relay_drive, 8'h00)
		run('{4, 32'h11462903, 4, 32'h11462900});
		`CHK(host_wd_expired, 1'b0)
		`CHK(din_value, din_pins)
		`CHK(relay_drive, ~dout_value)
		run('{3, 32'h114635, 4, 32'h1146351E});
		`CHK(ts >= 30 * CPM && ts <= 30 * CPM + 40, 1'b1)
		`CHK(delay_ms, 8'h1E)
		kick_on <= 1'b0;
		repeat (MWD + 10) @(posedge clk);
		`CHK(module_reset_req, 1'b1)
		kick_on <= 1'b1;
		repeat (15) @(posedge clk);
		`CHK(module_reset_req, 1'b0)
		clk_en <= 1'b0;
		din_pins <= ~din_pins;
		repeat (5) @(posedge clk);
		`CHK(din_value, ~din_pins)
		clk_en <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(din_value, din_pins)
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK(polarity_status, 8'h00)
		`CHK(delay_ms, 8'h00)
		run(rows[0]);
		own_addr <= 8'hF7;
		run('{3, 32'hF7462A, 4, 32'hF7462A00});
		own_addr <= 8'hF8;
		run('{3, 32'hF8462A, 0, 0});
		final_report;
	end
endmodule
bind mcf_handler mcf_handler_asserts #(.MOD_WD_CYC(MOD_WD_CYC)) i_chk (.clk, .rstn, .clk_en, .alive_kick, .din_pins,
	.dout_value, .rx_valid, .rx_ready, .tx_ready, .tx_byte, .tx_valid, .din_value, .relay_drive,
	.host_wd_expired, .module_reset_req, .polarity_status);
